/* File: hw/cmp_ref_pkg.sv */
package cmp_ref_pkg;

    // --------------------------------------------------------------
    // bus geometry
    // --------------------------------------------------------------
    localparam int          ADDR_W          = 5;        // byte address width
    localparam int          DATA_W          = 32;       // avalon data width
    localparam int          BE_W            = 4;        // byte enables

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [4:0]  OFS_MASK        = 5'h00;    // mask gate control
    localparam logic [4:0]  OFS_FILTER      = 5'h04;    // filter control
    localparam logic [4:0]  OFS_REF1        = 5'h08;    // reference control 1
    localparam logic [4:0]  OFS_REF2        = 5'h0C;    // reference control 2
    localparam logic [4:0]  OFS_STATUS      = 5'h10;    // live block state

    // --------------------------------------------------------------
    // mask gate fields
    // --------------------------------------------------------------
    localparam int          MSK_B_TRUE      = 3;        // and_b_true_enable
    localparam int          MSK_B_INV       = 2;        // and_b_inverted_enable
    localparam int          MSK_A_TRUE      = 1;        // and_a_true_enable
    localparam int          MSK_A_INV       = 0;        // and_a_inverted_enable
    localparam logic [3:0]  MSK_RESET       = 4'h0;

    // --------------------------------------------------------------
    // filter fields
    // --------------------------------------------------------------
    localparam int          FLT_SEL_LSB     = 4;        // filter_clock_select 6:4
    localparam int          FLT_EN_BIT      = 3;        // filter_enable
    localparam int          FLT_DIV_LSB     = 0;        // filter_clock_divide 2:0
    localparam int          FLT_W           = 7;        // implemented bits 6:0
    localparam logic [6:0]  FLT_RESET       = 7'h00;
    localparam logic [2:0]  SEL_RESERVED    = 3'h3;     // no clock source
    localparam int          FLT_AGREE       = 3;        // equal samples to switch

    // --------------------------------------------------------------
    // reference fields
    // --------------------------------------------------------------
    localparam int          REF_PWR_BIT     = 15;       // reference_power_enable
    localparam int          REF_PIN_BIT     = 14;       // reference_pin_output_enable
    localparam int          REF_SRC_BIT     = 11;       // reference_source_select
    localparam int          REF_INSEL_BIT   = 10;       // reference_input_select
    localparam int          REF_LVL_W       = 7;        // reference_level_code 6:0
    localparam logic [15:0] REF_WMASK       = 16'hCC7F; // implemented bits
    localparam logic [15:0] REF_RESET       = 16'h0000;

    // --------------------------------------------------------------
    // synchroniser inputs
    // --------------------------------------------------------------
    localparam int          N_SYNC          = 11;       // 8 source slots, result, a, b
    localparam int          SY_RESULT       = 8;
    localparam int          SY_MASK_A       = 9;

endpackage

/* File: hw/cmp_ref_ctrl.sv */
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

module cmp_ref_ctrl (
    // clock and reset
    input  logic                              clk,
    input  logic                              reset,
    // avalon-mm slave
    input  logic [cmp_ref_pkg::ADDR_W-1:0]    address,
    input  logic                              read,
    input  logic                              write,
    input  logic [cmp_ref_pkg::BE_W-1:0]      byteenable,
    input  logic [cmp_ref_pkg::DATA_W-1:0]    writedata,
    output logic [cmp_ref_pkg::DATA_W-1:0]    readdata,
    output logic                              waitrequest,
    // filter clock sources, sampled as levels
    input  logic                              peripheral_clock,
    input  logic                              oscillator_clock,
    input  logic                              pwm_sync_output_1,
    input  logic                              timer2_clock,
    input  logic                              timer3_clock,
    input  logic                              timer4_clock,
    input  logic                              timer5_clock,
    // comparator and mask inputs
    input  logic                              comparator_result,
    input  logic                              mask_input_a,
    input  logic                              mask_input_b,
    // digital results
    output logic                              comparator_output,
    output logic                              mask_gate_output,
    // reference 1 analog controls
    output logic                              ref1_power_enable,
    output logic                              reference1_output_pin,
    output logic                              ref1_source_external,
    output logic                              ref1_input_external,
    output logic [cmp_ref_pkg::REF_LVL_W-1:0] ref1_level_code,
    // reference 2 analog controls
    output logic                              ref2_power_enable,
    output logic                              reference2_output_pin,
    output logic                              ref2_source_external,
    output logic                              ref2_drives_inverting,
    output logic [cmp_ref_pkg::REF_LVL_W-1:0] ref2_level_code
);
    import cmp_ref_pkg::*;

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    logic [3:0]          mask_en_q;          // mask gate enables
    logic [FLT_W-1:0]    filter_q;           // filter control fields
    logic [15:0]         ref1_q;             // reference control 1
    logic [15:0]         ref2_q;             // reference control 2
    logic                wait_q;             // waitrequest, high when idle
    logic [DATA_W-1:0]   rdata_q;            // captured read word
    logic [N_SYNC-1:0]   raw_in;             // packed asynchronous inputs
    logic [N_SYNC-1:0]   sync1_q;            // first stage, read by sync2 only
    logic [N_SYNC-1:0]   sync2_q;            // safe sampled inputs
    logic                src_prev_q;         // selected source, last cycle
    logic                src_now;            // selected source, this cycle
    logic                src_rise;           // rising edge of source
    logic [6:0]          div_cnt_q;          // source edges counted
    logic                tick;               // divided sampling strobe
    logic [FLT_AGREE-1:0] hist_q;            // recent filter samples
    logic                cmp_out_q;          // comparator output flop
    logic                mask_out_q;         // mask gate output flop
    logic                ref2_drv_q;         // effective reference 2 choice
    logic                req;                // request present
    logic                ack;                // request completes this edge

    // --------------------------------------------------------------
    // helper functions
    // --------------------------------------------------------------
    // the word offset of an access, shared by write and read paths
    function automatic logic [4:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = {a[4:2], 2'b00};
    endfunction

    // last count value for a divide code: 2**code - 1
    function automatic logic [6:0] div_last(input logic [2:0] code);
        div_last = 7'(({7'h00, 1'b1} << code) - 8'h01);
    endfunction

    // --------------------------------------------------------------
    // avalon handshake
    // --------------------------------------------------------------
    assign req = read | write;
    assign ack = req & ~wait_q;

    // one wait state per access, then back to waiting; address is held
    // by the master so the word captured in the wait state is current
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;                  // answer on next edge
        end else begin
            wait_q <= 1'b1;                  // idle or just answered
        end
    end

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    // mask enables, low byte only
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_en_q <= MSK_RESET;
        end else if (write && ack && byteenable[0] && word_of(address) == OFS_MASK) begin
            mask_en_q <= writedata[3:0];
        end
    end

    // filter fields; bits above 6 have no storage
    always_ff @(posedge clk) begin
        if (reset) begin
            filter_q <= FLT_RESET;
        end else if (write && ack && byteenable[0] && word_of(address) == OFS_FILTER) begin
            filter_q <= writedata[FLT_W-1:0];
        end
    end

    // reference 1, byte lanes honoured, unused bits forced to zero
    always_ff @(posedge clk) begin
        if (reset) begin
            ref1_q <= REF_RESET;
        end else if (write && ack && word_of(address) == OFS_REF1) begin
            if (byteenable[0]) begin
                ref1_q[7:0] <= writedata[7:0] & REF_WMASK[7:0];
            end
            if (byteenable[1]) begin
                ref1_q[15:8] <= writedata[15:8] & REF_WMASK[15:8];
            end
        end
    end

    // reference 2, same layout as reference 1
    always_ff @(posedge clk) begin
        if (reset) begin
            ref2_q <= REF_RESET;
        end else if (write && ack && word_of(address) == OFS_REF2) begin
            if (byteenable[0]) begin
                ref2_q[7:0] <= writedata[7:0] & REF_WMASK[7:0];
            end
            if (byteenable[1]) begin
                ref2_q[15:8] <= writedata[15:8] & REF_WMASK[15:8];
            end
        end
    end

    // --------------------------------------------------------------
    // register reads
    // --------------------------------------------------------------
    // captured in the wait state so readdata stands at the ack edge;
    // unmapped offsets answer with zero rather than stalling the bus
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (read && wait_q) begin
            case (word_of(address))
                OFS_MASK:   rdata_q <= {28'h0000000, mask_en_q};
                OFS_FILTER: rdata_q <= {25'h0000000, filter_q};
                OFS_REF1:   rdata_q <= {16'h0000, ref1_q & REF_WMASK};
                OFS_REF2:   rdata_q <= {16'h0000, ref2_q & REF_WMASK};
                OFS_STATUS: rdata_q <= {30'h00000000, mask_out_q, cmp_out_q};
                default:    rdata_q <= '0;   // unmapped
            endcase
        end
    end

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    assign raw_in = {mask_input_b, mask_input_a, comparator_result, timer5_clock,
                     timer4_clock, timer3_clock, timer2_clock, 1'b0,
                     pwm_sync_output_1, oscillator_clock, peripheral_clock};

    // every outside level crosses two flops before any logic sees it
    generate
        for (genvar i = 0; i < N_SYNC; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (reset) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= raw_in[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // filter clock select and divider
    // --------------------------------------------------------------
    // reserved code 011 maps to a constant zero, so no edge ever comes;
    // sources must run below clk/4 to be seen reliably
    always_comb begin
        case (filter_q[FLT_SEL_LSB +: 3])
            SEL_RESERVED: src_now = 1'b0;
            default:      src_now = sync2_q[filter_q[FLT_SEL_LSB +: 3]];
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_now;
        end
    end

    assign src_rise = src_now & ~src_prev_q;
    assign tick     = src_rise && (div_cnt_q >= div_last(filter_q[FLT_DIV_LSB +: 3]));

    // counts source edges; wraps on the last edge of each period
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt_q <= 7'h00;
        end else if (tick || !filter_q[FLT_EN_BIT]) begin
            div_cnt_q <= 7'h00;
        end else if (src_rise) begin
            div_cnt_q <= div_cnt_q + 7'h01;
        end
    end

    // --------------------------------------------------------------
    // digital filter
    // --------------------------------------------------------------
    // shifts on the strobe; tracks the live level while bypassed, so no stale flip
    always_ff @(posedge clk) begin
        if (reset) begin
            hist_q <= '0;
        end else if (!filter_q[FLT_EN_BIT]) begin
            hist_q <= {FLT_AGREE{sync2_q[SY_RESULT]}};
        end else if (tick) begin
            hist_q <= {hist_q[FLT_AGREE-2:0], sync2_q[SY_RESULT]};
        end
    end

    // enabled: output moves only when all samples agree; disabled: the
    // synchronised result goes straight out, no divider latency
    always_ff @(posedge clk) begin
        if (reset) begin
            cmp_out_q <= 1'b0;
        end else if (!filter_q[FLT_EN_BIT]) begin
            cmp_out_q <= sync2_q[SY_RESULT];
        end else if (&hist_q) begin
            cmp_out_q <= 1'b1;
        end else if (~|hist_q) begin
            cmp_out_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // mask and gate
    // --------------------------------------------------------------
    // a cleared enable contributes a one, so no enables gives one
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_out_q <= 1'b1;
        end else begin
            mask_out_q <= (~mask_en_q[MSK_B_TRUE] |  sync2_q[SY_MASK_A+1])
                        & (~mask_en_q[MSK_B_INV]  | ~sync2_q[SY_MASK_A+1])
                        & (~mask_en_q[MSK_A_TRUE] |  sync2_q[SY_MASK_A])
                        & (~mask_en_q[MSK_A_INV]  | ~sync2_q[SY_MASK_A]);
        end
    end

    // --------------------------------------------------------------
    // reference selection
    // --------------------------------------------------------------
    // reference 2 only drives the input while reference 1 uses its network
    always_ff @(posedge clk) begin
        if (reset) begin
            ref2_drv_q <= 1'b0;
        end else begin
            ref2_drv_q <= ref2_q[REF_INSEL_BIT] & ~ref1_q[REF_INSEL_BIT];
        end
    end

    // --------------------------------------------------------------
    // outputs, all from flops
    // --------------------------------------------------------------
    assign readdata              = rdata_q;
    assign waitrequest           = wait_q;
    assign comparator_output     = cmp_out_q;
    assign mask_gate_output      = mask_out_q;
    assign ref1_power_enable     = ref1_q[REF_PWR_BIT];
    assign reference1_output_pin = ref1_q[REF_PIN_BIT];
    assign ref1_source_external  = ref1_q[REF_SRC_BIT];
    assign ref1_input_external   = ref1_q[REF_INSEL_BIT];
    assign ref1_level_code       = ref1_q[REF_LVL_W-1:0];
    assign ref2_power_enable     = ref2_q[REF_PWR_BIT];
    assign reference2_output_pin = ref2_q[REF_PIN_BIT];
    assign ref2_source_external  = ref2_q[REF_SRC_BIT];
    assign ref2_drives_inverting = ref2_drv_q;
    assign ref2_level_code       = ref2_q[REF_LVL_W-1:0];

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    mask_b_true_a: assert property (@(posedge clk) disable iff (reset)
        $past(mask_en_q[MSK_B_TRUE] & ~sync2_q[SY_MASK_A+1]) |-> !mask_out_q)
        else $error("enabled b term low did not force mask output low");

    mask_none_a: assert property (@(posedge clk) disable iff (reset)
        $past(mask_en_q == 4'h0) |-> mask_out_q)
        else $error("mask output low with no term enabled");

    reserved_clock_a: assert property (@(posedge clk) disable iff (reset)
        filter_q[FLT_SEL_LSB +: 3] == SEL_RESERVED |-> !tick)
        else $error("sampling strobe from reserved source");

    divide_wrap_a: assert property (@(posedge clk) disable iff (reset)
        tick |=> div_cnt_q == 7'h00)
        else $error("divider did not wrap after strobe");

    filter_bypass_a: assert property (@(posedge clk) disable iff (reset)
        !filter_q[FLT_EN_BIT] |=> cmp_out_q == $past(sync2_q[SY_RESULT]))
        else $error("bypassed output lags the synchronised result");

    filter_read_a: assert property (@(posedge clk) disable iff (reset)
        read && ack && word_of(address) == OFS_FILTER |-> rdata_q[31:7] == 25'h0)
        else $error("filter unused bits read nonzero");

    ref_read_a: assert property (@(posedge clk) disable iff (reset)
        read && ack && word_of(address) == OFS_REF1
        |-> rdata_q[13:12] == 2'h0 && rdata_q[9:7] == 3'h0)
        else $error("reference unused bits read nonzero");

    ref_power_a: assert property (@(posedge clk) disable iff (reset)
        write && ack && byteenable[1] && word_of(address) == OFS_REF1
        |=> ref1_power_enable == $past(writedata[REF_PWR_BIT]))
        else $error("power enable did not follow write");

    ref_level_a: assert property (@(posedge clk) disable iff (reset)
        write && ack && byteenable[0] && word_of(address) == OFS_REF2
        |=> ref2_level_code == $past(writedata[6:0]))
        else $error("level code did not follow write");

    ref2_gate_a: assert property (@(posedge clk) disable iff (reset)
        ref1_q[REF_INSEL_BIT] |=> !ref2_drives_inverting)
        else $error("reference two drives while reference one is external");

    bus_answer_a: assert property (@(posedge clk) disable iff (reset)
        req && wait_q |=> !waitrequest)
        else $error("request not answered after one wait state");

    filter_tick_c: cover property (@(posedge clk) disable iff (reset)
        filter_q[FLT_EN_BIT] && tick);
    filter_switch_c: cover property (@(posedge clk) disable iff (reset)
        filter_q[FLT_EN_BIT] ##1 $rose(cmp_out_q));
    bus_write_c: cover property (@(posedge clk) disable iff (reset) write && ack);
    bus_read_c: cover property (@(posedge clk) disable iff (reset) read && ack);

endmodule

/* File: verification/test_comparator_filter_and_reference_ctrl.sv */
`timescale 1ns/1ps
module test_comparator_filter_and_reference_ctrl;
    import cmp_ref_pkg::*;
    // ----------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------
    logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q, d, e;
    logic        waitrequest, comparator_output, mask_gate_output;
    logic        comparator_result = 1'b0, mask_input_a = 1'b0, mask_input_b = 1'b0;
    logic        ref1_power_enable, reference1_output_pin, ref1_source_external;
    logic        ref1_input_external, ref2_power_enable, reference2_output_pin;
    logic        ref2_source_external, ref2_drives_inverting;
    logic [6:0]  ref1_level_code, ref2_level_code;
    logic [7:0]  src_q = 8'h00;    // slow levels standing in for the clock sources
    logic [15:0] s1, s2;           // register shadows
    logic [4:0]  a;
    int          miscompares = 0, cmp_count = 0, i, n;
    always #2 clk = ~clk;
    always @(posedge clk) src_q <= src_q + 8'h01;
    cmp_ref_ctrl dut (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .peripheral_clock(src_q[3]),
        .oscillator_clock(src_q[4]), .pwm_sync_output_1(src_q[2]), .timer2_clock(src_q[5]),
        .timer3_clock(src_q[3]), .timer4_clock(src_q[4]), .timer5_clock(src_q[2]),
        .comparator_result(comparator_result), .mask_input_a(mask_input_a),
        .mask_input_b(mask_input_b), .comparator_output(comparator_output),
        .mask_gate_output(mask_gate_output), .ref1_power_enable(ref1_power_enable),
        .reference1_output_pin(reference1_output_pin),
        .ref1_source_external(ref1_source_external), .ref1_input_external(ref1_input_external),
        .ref1_level_code(ref1_level_code), .ref2_power_enable(ref2_power_enable),
        .reference2_output_pin(reference2_output_pin),
        .ref2_source_external(ref2_source_external),
        .ref2_drives_inverting(ref2_drives_inverting), .ref2_level_code(ref2_level_code));
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic give_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask
    // one avalon access; the request stands until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
        int k;
        @(posedge clk);
        address <= ad;
        writedata <= wd;
        byteenable <= 4'hF;
        write <= wr;
        read <= !wr;
        k = 0;
        do begin @(posedge clk); k++; end while (waitrequest !== 1'b0 && k < 16);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0) begin miscompares++; give_verdict(); end
    endtask
    function automatic logic [31:0] rexp(input logic [4:0] ad, input logic [31:0] wd);
        if (ad == OFS_MASK) return wd & 32'h0000000F;
        if (ad == OFS_FILTER) return wd & 32'h0000007F;
        return wd & {16'h0000, REF_WMASK};
    endfunction
    // an enabled term restricts, a cleared one is don't-care
    function automatic logic mexp(input logic [3:0] en, input logic ma, input logic mb);
        return (!en[3] | mb) & (!en[2] | !mb) & (!en[1] | ma) & (!en[0] | !ma);
    endfunction
    // cycles between sampling strobes for select s, from the bench's own source wiring
    function automatic int span(input int s);
        int b;
        b = (s == 2 || s == 7) ? 2 : (s == 0 || s == 5) ? 3 : (s == 4) ? 5 : 4;
        return (2 << b) << (s & 1);
    endfunction
    // bounded wait for the filtered output to follow the raw result
    task automatic follow;
        n = 0;
        while (comparator_output !== comparator_result && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check(32'(comparator_output), 32'(comparator_result));
        if (n >= 1000) give_verdict();
    endtask
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        void'($urandom(6651));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // reset values, status shows mask out high, unmapped reads zero
        for (i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            check(q, (i == 4) ? 32'h00000002 : 32'h0);
        end
        s1 = 16'h0000;
        s2 = 16'h0000;
        // random register traffic, implemented bits only survive
        repeat (40) begin
            a = 5'($urandom_range(3) * 4);
            d = $urandom;
            e = rexp(a, d);
            bus(1'b1, a, d);
            bus(1'b0, a, 32'h0);
            check(q, e);
            if (a == OFS_REF1) s1 = e[15:0];
            if (a == OFS_REF2) s2 = e[15:0];
            check(32'({ref1_power_enable, reference1_output_pin, ref1_source_external,
                ref1_input_external, ref1_level_code}),
                32'({s1[15], s1[14], s1[11], s1[10], s1[6:0]}));
            check(32'({ref2_power_enable, reference2_output_pin, ref2_source_external,
                ref2_drives_inverting, ref2_level_code}),
                32'({s2[15], s2[14], s2[11], s2[10] & !s1[10], s2[6:0]}));
        end
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        bus(1'b0, 5'h14, 32'h0);
        check(q, 32'h0);
        // give the reference time to settle before judging comparator results
        repeat (8) @(posedge clk);
        // every enable pattern against every input pair, filter bypassed
        bus(1'b1, OFS_FILTER, 32'h0);
        for (i = 0; i < 64; i++) begin
            bus(1'b1, OFS_MASK, 32'(i >> 2));
            mask_input_a <= i[0];
            mask_input_b <= i[1];
            repeat (4) @(posedge clk);
            #1 check(32'(mask_gate_output), 32'(mexp(4'(i >> 2), i[0], i[1])));
        end
        // bypass latency is exactly the sync plus output flop
        @(posedge clk);
        comparator_result <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(32'(comparator_output), 32'h0);
        @(posedge clk);
        #1 check(32'(comparator_output), 32'h1);
        // each real source, filter enabled: slow to follow, but follows
        for (i = 0; i < 8; i++) if (i != 3) begin
            bus(1'b1, OFS_FILTER, 32'((i << 4) | 8 | (i & 1)));
            comparator_result <= ~comparator_result;
            repeat (span(i)) @(posedge clk);
            #1 check(32'(comparator_output), 32'(!comparator_result));
            follow();
        end
        // reserved source holds, largest divide is too slow to follow soon
        bus(1'b1, OFS_FILTER, 32'h00000038);
        comparator_result <= ~comparator_result;
        repeat (300) @(posedge clk);
        #1 check(32'(comparator_output), 32'(!comparator_result));
        bus(1'b1, OFS_FILTER, 32'h0000000F);
        repeat (1000) @(posedge clk);
        #1 check(32'(comparator_output), 32'(!comparator_result));
        give_verdict();
    end
endmodule
